//--- vcc_analog_model.sv
// Behavioural analog front end that makes the raw comparator result
`default_nettype none
module vcc_analog_model #(
    parameter int VREF_INT_MV = 815,
    parameter int DLY_FAST_NS = 3,
    parameter int DLY_SLOW_NS = 23
) (
    input var int vin_mv,
    input var int vext_mv,
    input wire logic ref_internal_sel,
    input wire logic high_speed_sel,
    input wire logic comparator_enable,
    output logic comparator_raw
);
    timeunit 1ns;
    timeprecision 100ps;
    int vref;
    // Reference from the pin or the on-chip source
    assign vref = ref_internal_sel ? VREF_INT_MV : vext_mv;
    // Result settles after the delay of the chosen speed mode
    always @(vin_mv or vref or comparator_enable or high_speed_sel) begin
        if (high_speed_sel) begin
            comparator_raw <= #(DLY_FAST_NS)
                comparator_enable && vin_mv > vref;
        end else begin
            comparator_raw <= #(DLY_SLOW_NS)
                comparator_enable && vin_mv > vref;
        end
    end
endmodule
`default_nettype wire

//--- vcc_comparator_ctrl.sv
// Control logic of the voltage comparator with its clock gate
// Summary of operation
// - High-speed or low-speed response selected by a control bit
// - Reference is external pin or on-chip voltage by select bit
// - Digital noise filter with selectable width, can be disabled
// - Result drives output pin, inverted or not by polarity bit
// - Interrupt raised on selected effective edge of the output
// - Clock-enable low stops clock and holds comparator in reset
// - Clock-enable low holds control registers at reset, ignores writes
// - Clock-enable high supplies clock, registers read and write
// - System reset clears whole peripheral enable register
// - Peripheral enable register takes bit and byte writes
// - Monitor flag reads 1 above reference, 0 below
// - Edge select 00 rising, 01 falling, upper bit set both
// - Filter passes level stable three samples; clock /1, /8, /32
// - Interrupt only while interrupt-enable bit set
`default_nettype none
module vcc_comparator_ctrl (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [19:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_bit_op,
    input wire logic [2:0] sfr_bit_sel,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    input wire logic comparator_raw,
    output logic [7:0] peripheral_clock_enable,
    output logic comparator_clock_on,
    output logic comparator_enable,
    output logic ref_internal_sel,
    output logic high_speed_sel,
    output logic comparator_out_pin,
    output logic comparator_out_oe,
    output logic comparator_irq
);
    // ************************************************
    // Register file
    // ************************************************
    logic [7:0] per_ff, nxt_per;
    logic [7:0] mdr_ff, nxt_mdr;
    logic [7:0] fir_ff, nxt_fir;
    logic [7:0] ocr_ff, nxt_ocr;
    logic [7:0] rdata_ff, nxt_rdata;
    logic [7:0] bit_mask;
    logic clk_on;
    logic mon_level;

    // Merge a bit or byte write into the old value
    function automatic logic [7:0] merge(input logic [7:0] old,
                                         input logic [7:0] bm,
                                         input logic bit_op,
                                         input logic [7:0] wd,
                                         input logic [7:0] wmask);
        logic [7:0] v;
        v = bit_op ? ((old & ~bm) | (wd[0] ? bm : vcc_pkg::RESET_VAL)) : wd;
        return v & wmask;
    endfunction

    assign clk_on = per_ff[vcc_pkg::PER_CMP];
    assign bit_mask = 8'h01 << sfr_bit_sel;

    // Next register values and read data
    always_comb begin
        nxt_per = per_ff;
        nxt_mdr = mdr_ff;
        nxt_fir = fir_ff;
        nxt_ocr = ocr_ff;
        nxt_rdata = rdata_ff;
        if (sfr_wr) begin
            if (sfr_addr == vcc_pkg::ADDR_PER) begin
                nxt_per = merge(per_ff, bit_mask, sfr_bit_op, sfr_wdata,
                                vcc_pkg::MASK_PER);
            end else if (sfr_addr == vcc_pkg::ADDR_MDR) begin
                nxt_mdr = merge(mdr_ff, bit_mask, sfr_bit_op, sfr_wdata,
                                vcc_pkg::MASK_MDR);
            end else if (sfr_addr == vcc_pkg::ADDR_FIR) begin
                nxt_fir = merge(fir_ff, bit_mask, sfr_bit_op, sfr_wdata,
                                vcc_pkg::MASK_FIR);
            end else if (sfr_addr == vcc_pkg::ADDR_OCR) begin
                nxt_ocr = merge(ocr_ff, bit_mask, sfr_bit_op, sfr_wdata,
                                vcc_pkg::MASK_OCR);
            end
        end
        // Gate off: control registers forced to reset value
        if (!clk_on) begin
            nxt_mdr = vcc_pkg::RESET_VAL;
            nxt_fir = vcc_pkg::RESET_VAL;
            nxt_ocr = vcc_pkg::RESET_VAL;
        end
        if (sfr_rd) begin
            if (sfr_addr == vcc_pkg::ADDR_PER) begin
                nxt_rdata = per_ff;
            end else if (sfr_addr == vcc_pkg::ADDR_MDR) begin
                nxt_rdata = mdr_ff;
                nxt_rdata[vcc_pkg::MDR_MON] = mon_level;
            end else if (sfr_addr == vcc_pkg::ADDR_FIR) begin
                nxt_rdata = fir_ff;
            end else if (sfr_addr == vcc_pkg::ADDR_OCR) begin
                nxt_rdata = ocr_ff;
            end else begin
                nxt_rdata = vcc_pkg::RESET_VAL;
            end
        end
    end

    // Register storage, cleared by system reset
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            per_ff <= vcc_pkg::RESET_VAL;
            mdr_ff <= vcc_pkg::RESET_VAL;
            fir_ff <= vcc_pkg::RESET_VAL;
            ocr_ff <= vcc_pkg::RESET_VAL;
            rdata_ff <= vcc_pkg::RESET_VAL;
        end else begin
            per_ff <= nxt_per;
            mdr_ff <= nxt_mdr;
            fir_ff <= nxt_fir;
            ocr_ff <= nxt_ocr;
            rdata_ff <= nxt_rdata;
        end
    end

    // ************************************************
    // Synchroniser, filter, edge detect, pin
    // ************************************************
    logic sync1_ff, sync2_ff;
    logic [4:0] pre_ff, nxt_pre;
    logic [2:0] samp_ff, nxt_samp;
    logic filt_ff, nxt_filt;
    logic prev_ff, nxt_prev;
    logic irq_ff, nxt_irq;
    logic pin_ff, nxt_pin;
    logic [1:0] fck;
    logic enb;
    logic tick;
    logic rise, fall, hit;

    assign fck = fir_ff[1:0];
    assign enb = clk_on & mdr_ff[vcc_pkg::MDR_ENB];
    assign mon_level = enb & sync2_ff;

    // Sampling tick, filter and edge logic
    always_comb begin
        nxt_pre = pre_ff + 5'h01;
        if (fck == vcc_pkg::FCK_DIV1) begin
            tick = 1'b1;
        end else if (fck == vcc_pkg::FCK_DIV8) begin
            tick = (pre_ff[2:0] == vcc_pkg::DIV8_LAST);
        end else begin
            tick = (pre_ff == vcc_pkg::DIV32_LAST);
        end
        nxt_samp = samp_ff;
        nxt_filt = filt_ff;
        if (fck == vcc_pkg::FCK_OFF) begin
            nxt_filt = sync2_ff;
        end else begin
            if (tick) begin
                nxt_samp = {samp_ff[1:0], sync2_ff};
            end
            if (samp_ff == vcc_pkg::STABLE_ALL1) begin
                nxt_filt = 1'b1;
            end else if (samp_ff == vcc_pkg::STABLE_ALL0) begin
                nxt_filt = 1'b0;
            end
        end
        nxt_prev = filt_ff;
        rise = filt_ff & ~prev_ff;
        fall = ~filt_ff & prev_ff;
        if (fir_ff[vcc_pkg::FIR_EDG]) begin
            hit = rise | fall;
        end else if (fir_ff[vcc_pkg::FIR_EPO]) begin
            hit = fall;
        end else begin
            hit = rise;
        end
        nxt_irq = hit & enb & ocr_ff[vcc_pkg::OCR_IE];
        nxt_pin = filt_ff ^ ocr_ff[vcc_pkg::OCR_OP];
        // Gate off: comparator logic held in reset
        if (!enb) begin
            nxt_pre = 5'h00;
            nxt_samp = vcc_pkg::STABLE_ALL0;
            nxt_filt = 1'b0;
            nxt_prev = 1'b0;
            nxt_irq = 1'b0;
        end
    end

    // Comparator path state
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            pre_ff <= 5'h00;
            samp_ff <= 3'h0;
            filt_ff <= 1'b0;
            prev_ff <= 1'b0;
            irq_ff <= 1'b0;
            pin_ff <= 1'b0;
        end else begin
            sync1_ff <= comparator_raw;
            sync2_ff <= sync1_ff;
            pre_ff <= nxt_pre;
            samp_ff <= nxt_samp;
            filt_ff <= nxt_filt;
            prev_ff <= nxt_prev;
            irq_ff <= nxt_irq;
            pin_ff <= nxt_pin;
        end
    end

    // Outputs straight from flip-flops
    assign sfr_rdata = rdata_ff;
    assign peripheral_clock_enable = per_ff;
    assign comparator_clock_on = per_ff[vcc_pkg::PER_CMP];
    assign comparator_enable = mdr_ff[vcc_pkg::MDR_ENB];
    assign ref_internal_sel = mdr_ff[vcc_pkg::MDR_VRF];
    assign high_speed_sel = ocr_ff[vcc_pkg::OCR_SPD];
    assign comparator_out_pin = pin_ff;
    assign comparator_out_oe = ocr_ff[vcc_pkg::OCR_OE];
    assign comparator_irq = irq_ff;

    // ************************************************
    // Checks
    // ************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    property p_clkoff_hold;
        !clk_on |=> mdr_ff == vcc_pkg::RESET_VAL
            && fir_ff == vcc_pkg::RESET_VAL && ocr_ff == vcc_pkg::RESET_VAL;
    endproperty
    a_clkoff_hold: assert property (p_clkoff_hold)
        else $error("control register not held while clock off");

    property p_irq_gate;
        comparator_irq |-> $past(ocr_ff[vcc_pkg::OCR_IE]) && $past(enb);
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt while disabled");

    property p_irq_edge;
        comparator_irq |-> $past(filt_ff) != $past(prev_ff);
    endproperty
    a_irq_edge: assert property (p_irq_edge)
        else $error("interrupt without edge");

    property p_rise_only;
        comparator_irq && !$past(fir_ff[vcc_pkg::FIR_EDG])
            && !$past(fir_ff[vcc_pkg::FIR_EPO]) |-> $past(filt_ff);
    endproperty
    a_rise_only: assert property (p_rise_only)
        else $error("wrong edge for rising selection");

    property p_pin_pol;
        1'b1 |=> comparator_out_pin
            == $past(filt_ff ^ ocr_ff[vcc_pkg::OCR_OP]);
    endproperty
    a_pin_pol: assert property (p_pin_pol)
        else $error("output pin polarity wrong");

    property p_sync;
        1'b1 |-> ##2 sync2_ff == $past(comparator_raw, 2);
    endproperty
    a_sync: assert property (p_sync)
        else $error("synchroniser latency wrong");

    property p_filter3;
        fck != vcc_pkg::FCK_OFF && $past(fck) != vcc_pkg::FCK_OFF
            && $past(enb) && filt_ff != $past(filt_ff)
            |-> $past(samp_ff) == {3{filt_ff}};
    endproperty
    a_filter3: assert property (p_filter3)
        else $error("filter passed unstable level");

    property p_bitwr;
        sfr_wr && sfr_bit_op && sfr_addr == vcc_pkg::ADDR_PER
            |=> (per_ff & ~$past(bit_mask)) ==
                ($past(per_ff) & ~$past(bit_mask));
    endproperty
    a_bitwr: assert property (p_bitwr)
        else $error("bit write touched other bits");

    property p_off_quiet;
        !enb |=> !comparator_irq;
    endproperty
    a_off_quiet: assert property (p_off_quiet)
        else $error("interrupt while comparator held in reset");

    property p_mon_read;
        sfr_rd && sfr_addr == vcc_pkg::ADDR_MDR
            |=> sfr_rdata[vcc_pkg::MDR_MON] == $past(sync2_ff && enb);
    endproperty
    a_mon_read: assert property (p_mon_read)
        else $error("monitor flag does not follow result");

    // Main scenarios reached
    c_irq_both: cover property (comparator_irq && fir_ff[3]);
    c_irq_fall: cover property (comparator_irq
        && fir_ff[vcc_pkg::FIR_EPO] && !fir_ff[vcc_pkg::FIR_EDG]);
    c_filter32: cover property (&fck && filt_ff != $past(filt_ff));
    c_clk_off: cover property ($fell(clk_on));
endmodule
`default_nettype wire

//--- vcc_pkg.sv
// Constants for the voltage comparator control block
`default_nettype none
package vcc_pkg;
    // ************************************************
    // Register addresses
    // ************************************************
    localparam logic [19:0] ADDR_PER = 20'hF00F0;
    localparam logic [19:0] ADDR_MDR = 20'hFFF60;
    localparam logic [19:0] ADDR_FIR = 20'hFFF61;
    localparam logic [19:0] ADDR_OCR = 20'hFFF62;
    localparam logic [7:0] RESET_VAL = 8'h00;
    // ************************************************
    // Writable bits per register
    // ************************************************
    localparam logic [7:0] MASK_PER = 8'hF5;
    localparam logic [7:0] MASK_MDR = 8'h05;
    localparam logic [7:0] MASK_FIR = 8'h0F;
    localparam logic [7:0] MASK_OCR = 8'h87;
    // ************************************************
    // Field positions
    // ************************************************
    localparam int PER_CMP = 5;
    localparam int MDR_ENB = 0;
    localparam int MDR_VRF = 2;
    localparam int MDR_MON = 3;
    localparam int FIR_EPO = 2;
    localparam int FIR_EDG = 3;
    localparam int OCR_IE = 0;
    localparam int OCR_OE = 1;
    localparam int OCR_OP = 2;
    localparam int OCR_SPD = 7;
    // ************************************************
    // Filter sampling clock selection
    // ************************************************
    localparam logic [1:0] FCK_OFF = 2'h0;
    localparam logic [1:0] FCK_DIV1 = 2'h1;
    localparam logic [1:0] FCK_DIV8 = 2'h2;
    localparam logic [2:0] DIV8_LAST = 3'h7;
    localparam logic [4:0] DIV32_LAST = 5'h1F;
    localparam logic [2:0] STABLE_ALL1 = 3'h7;
    localparam logic [2:0] STABLE_ALL0 = 3'h0;
endpackage
`default_nettype wire

//--- voltage_comparator_with_clock_gate_test.sv
// Self-checking bench for the comparator control block
`default_nettype none
module voltage_comparator_with_clock_gate_test;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int HI = 900;
    localparam int LO = 700;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [19:0] sfr_addr = 20'h00000;
    logic sfr_wr = 1'b0;
    logic sfr_bit_op = 1'b0;
    logic [2:0] sfr_bit_sel = 3'h0;
    logic [7:0] sfr_wdata = 8'h00;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_rdata, peripheral_clock_enable;
    logic comparator_clock_on, comparator_enable, ref_internal_sel;
    logic high_speed_sel, comparator_out_pin, comparator_out_oe;
    logic comparator_irq, comparator_raw;
    int vin_mv = LO;
    int vext_mv = 500;
    int irq_cnt = 0;
    int bad_count = 0;
    int checked = 0;
    // Clock and interrupt pulse counter
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        if (comparator_irq === 1'b1) begin
            irq_cnt <= irq_cnt + 1;
        end
    end
    vcc_comparator_ctrl i_dut (.sys_clk, .reset, .sfr_addr, .sfr_wr,
        .sfr_bit_op, .sfr_bit_sel, .sfr_wdata, .sfr_rd, .sfr_rdata,
        .comparator_raw, .peripheral_clock_enable, .comparator_clock_on,
        .comparator_enable, .ref_internal_sel, .high_speed_sel,
        .comparator_out_pin, .comparator_out_oe, .comparator_irq);
    vcc_analog_model i_src (.vin_mv, .vext_mv, .ref_internal_sel,
        .high_speed_sel, .comparator_enable, .comparator_raw);
    // ****************************************
    // Bus tasks and comparison
    // ****************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [19:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_bit_op <= 1'b0;
        sfr_wr <= 1'b1;
        @(posedge sys_clk);
        sfr_wr <= 1'b0;
        #1; // Let the written register settle
    endtask
    task automatic bwr(input logic [19:0] a, input logic [2:0] b,
                       input logic v);
        @(posedge sys_clk);
        sfr_addr <= a;
        sfr_bit_sel <= b;
        sfr_wdata <= {7'h00, v};
        sfr_bit_op <= 1'b1;
        sfr_wr <= 1'b1;
        @(posedge sys_clk);
        sfr_wr <= 1'b0;
        #1; // Let the written register settle
    endtask
    task automatic rd(input logic [19:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge sys_clk);
        sfr_rd <= 1'b0;
        #1 chk(sfr_rdata, e);
    endtask
    task automatic go(input int mv, input int cyc);
        @(posedge sys_clk);
        vin_mv <= mv;
        repeat (cyc) @(posedge sys_clk);
        #1;
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        rd(vcc_pkg::ADDR_PER, 8'h00);
        chk({comparator_irq, comparator_out_pin, comparator_out_oe,
             comparator_clock_on, comparator_enable, 3'h0}, 8'h00);
        chk(peripheral_clock_enable, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_gate;
        wr(vcc_pkg::ADDR_MDR, 8'h05);
        rd(vcc_pkg::ADDR_MDR, 8'h00);
        wr(vcc_pkg::ADDR_PER, 8'hF5);
        rd(vcc_pkg::ADDR_PER, 8'hF5);
        bwr(vcc_pkg::ADDR_PER, 3'h0, 1'b0);
        rd(vcc_pkg::ADDR_PER, 8'hF4);
        chk(peripheral_clock_enable, 8'hF4);
        chk({7'h00, comparator_clock_on}, 8'h01);
        rd(20'h00000, 8'h00);
        $display("test gate done");
    endtask
    task automatic t_regs;
        wr(vcc_pkg::ADDR_MDR, 8'h05);
        rd(vcc_pkg::ADDR_MDR, 8'h05);
        chk({6'h00, ref_internal_sel, comparator_enable}, 8'h03);
        wr(vcc_pkg::ADDR_OCR, 8'h83);
        chk({6'h00, high_speed_sel, comparator_out_oe}, 8'h03);
        go(HI, 8);
        rd(vcc_pkg::ADDR_MDR, 8'h0D);
        go(LO, 8);
        rd(vcc_pkg::ADDR_MDR, 8'h05);
        $display("test regs done");
    endtask
    task automatic t_edges;
        logic [7:0] fir[3] = '{8'h00, 8'h04, 8'h08};
        logic [7:0] up[3] = '{8'h01, 8'h00, 8'h01};
        logic [7:0] dn[3] = '{8'h00, 8'h01, 8'h01};
        int n0;
        for (int i = 0; i < 3; i++) begin
            wr(vcc_pkg::ADDR_FIR, fir[i]);
            n0 = irq_cnt;
            go(HI, 12);
            chk(8'(irq_cnt - n0), up[i]);
            n0 = irq_cnt;
            go(LO, 12);
            chk(8'(irq_cnt - n0), dn[i]);
        end
        $display("test edges done");
    endtask
    task automatic t_filter;
        int n0;
        wr(vcc_pkg::ADDR_FIR, 8'h01);
        go(LO, 8);
        n0 = irq_cnt;
        go(HI, 1);
        go(LO, 12);
        chk({7'h00, comparator_out_pin}, 8'h00);
        go(HI, 12);
        chk({7'h00, comparator_out_pin}, 8'h01);
        chk(8'(irq_cnt - n0), 8'h01);
        wr(vcc_pkg::ADDR_OCR, 8'h85);
        go(HI, 4);
        chk({7'h00, comparator_out_pin}, 8'h00);
        wr(vcc_pkg::ADDR_FIR, 8'h06);
        go(HI, 40);
        go(LO, 10);
        go(HI, 40);
        chk({7'h00, comparator_out_pin}, 8'h00);
        go(LO, 60);
        chk({7'h00, comparator_out_pin}, 8'h01);
        wr(vcc_pkg::ADDR_FIR, 8'h07);
        go(HI, 40);
        chk({7'h00, comparator_out_pin}, 8'h01);
        go(HI, 100);
        chk({7'h00, comparator_out_pin}, 8'h00);
        $display("test filter done");
    endtask
    task automatic t_ie;
        int n0;
        wr(vcc_pkg::ADDR_OCR, 8'h82);
        wr(vcc_pkg::ADDR_FIR, 8'h08);
        n0 = irq_cnt;
        go(LO, 12);
        go(HI, 12);
        chk(8'(irq_cnt - n0), 8'h00);
        bwr(vcc_pkg::ADDR_PER, 3'h5, 1'b0);
        rd(vcc_pkg::ADDR_OCR, 8'h00);
        chk({7'h00, comparator_enable}, 8'h00);
        n0 = irq_cnt;
        go(HI, 12);
        chk(8'(irq_cnt - n0), 8'h00);
        $display("test ie done");
    endtask
    // Main sequence
    initial begin
        repeat (20) @(posedge sys_clk);
        reset <= 1'b0;
        t_reset;
        t_gate;
        t_regs;
        t_edges;
        t_filter;
        t_ie;
        wrap_up;
    end
    // Hang guard
    initial begin
        repeat (100000) @(posedge sys_clk);
        bad_count++;
        wrap_up;
    end
endmodule
`default_nettype wire
